/* adc_result_consts.svh */
// named constants for the converter result and configuration block
`ifndef ADC_RESULT_CONSTS_SVH
`define ADC_RESULT_CONSTS_SVH

// word indices on the register bus
`define ADDR_W 3
`define OFF_CONTROL_TWO 3'h0
`define OFF_RESULT_HIGH 3'h1
`define OFF_RESULT_LOW 3'h2
`define OFF_CONV_CONTROL 3'h3
`define OFF_IRQ_STATUS 3'h4
`define OFF_IRQ_CLEAR 3'h5
`define OFF_IRQ_ENABLE 3'h6

// converter_control_two layout
`define CTRL2_RESET 8'h00
`define CTRL2_WMASK 8'hf3
`define JUSTIFY_BIT 7
`define CLKSEL_MSB 6
`define CLKSEL_LSB 4
`define PREF_MSB 1
`define PREF_LSB 0

// conversion control layout
`define CONV_ENABLE_BIT 0
`define CONV_GO_BIT 1

// interrupt layout
`define IRQ_W 1
`define IRQ_DONE_BIT 0
`define IRQ_RESET 1'h0

// conversion clock select codes
`define CLKSEL_DIV2 3'h0
`define CLKSEL_DIV8 3'h1
`define CLKSEL_DIV32 3'h2
`define CLKSEL_RC 3'h3
`define CLKSEL_DIV4 3'h4
`define CLKSEL_DIV16 3'h5
`define CLKSEL_DIV64 3'h6
`define CLKSEL_RC_ALT 3'h7

// divider masks: ratio minus one
`define DIV_W 6
`define MASK_DIV2 6'h01
`define MASK_DIV4 6'h03
`define MASK_DIV8 6'h07
`define MASK_DIV16 6'h0f
`define MASK_DIV32 6'h1f
`define MASK_DIV64 6'h3f

// conversion length in conversion clock ticks
`define TICK_W 4
`define CONV_TICKS 4'hb
`define TICK_ZERO 4'h0
`define TICK_ONE 4'h1

`define RESULT_W 10
`define BYTE_W 8

`endif

/* adc_result_pkg.sv */
// types shared by the converter result and configuration block
package adc_result_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_convert = 3'b010,
    st_finish = 3'b100
  } conv_state_t;
endpackage

/* conv_clock_divider.sv */
// conversion clock enable: system clock divided, or the rc tick
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_consts.svh"
module conv_clock_divider (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [2:0] clock_select, // conversion clock select field
  input wire logic rc_pulse, // one-cycle pulse per rc oscillator period
  output logic conv_tick // one-cycle conversion clock enable
);
  logic [`DIV_W-1:0] count_reg;
  logic [`DIV_W-1:0] div_mask;
  wire use_rc;
  wire div_hit;

  always_comb begin
    unique case (clock_select)
      `CLKSEL_DIV2: div_mask = `MASK_DIV2;
      `CLKSEL_DIV4: div_mask = `MASK_DIV4;
      `CLKSEL_DIV8: div_mask = `MASK_DIV8;
      `CLKSEL_DIV16: div_mask = `MASK_DIV16;
      `CLKSEL_DIV32: div_mask = `MASK_DIV32;
      `CLKSEL_DIV64: div_mask = `MASK_DIV64;
      default: div_mask = `MASK_DIV64;
    endcase
  end

  assign use_rc = (clock_select == `CLKSEL_RC) ||
                  (clock_select == `CLKSEL_RC_ALT);
  assign div_hit = ((count_reg & div_mask) == div_mask);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      conv_tick <= 1'b0;
    end else begin
      count_reg <= count_reg + 1'b1;
      conv_tick <= use_rc ? rc_pulse : div_hit;
    end
  end
endmodule // conv_clock_divider
`default_nettype wire

/* result_formatter.sv */
// places the 10-bit result into the high and low result bytes
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_consts.svh"
module result_formatter (
  input wire logic [`RESULT_W-1:0] conversion_result, // finished result
  input wire logic result_justify_select, // 1 right, 0 left justified
  output logic [`BYTE_W-1:0] high_byte, // value for result_high_byte
  output logic [`BYTE_W-1:0] low_byte // value for result_low_byte
);
  // reserved bits are written as zero so software sees a clean value
  assign high_byte = result_justify_select ?
    {6'h00, conversion_result[9:8]} :
    conversion_result[9:2];
  assign low_byte = result_justify_select ?
    conversion_result[7:0] :
    {conversion_result[1:0], 6'h00};
endmodule // result_formatter
`default_nettype wire

/* adc_result_format_config.sv */
// converter configuration, result registers and conversion sequencing
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_consts.svh"
module adc_result_format_config (
  input wire logic clock, // 50 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic [`ADDR_W-1:0] address, // avalon word address
  input wire logic read, // avalon read request
  input wire logic write, // avalon write request
  input wire logic [3:0] byteenable, // avalon byte enables
  input wire logic [31:0] writedata, // avalon write data
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait, high until answered
  input wire logic [`RESULT_W-1:0] conversion_sample, // front-end value
  input wire logic rc_osc_pin, // dedicated rc oscillator, async
  output logic irq, // level interrupt
  output logic [1:0] positive_reference_select, // reference choice
  output logic converter_enable, // converter powered
  output logic conversion_active // conversion in progress
);
  adc_result_pkg::conv_state_t state_reg;
  adc_result_pkg::conv_state_t state_next;
  logic [`BYTE_W-1:0] control_two_reg;
  logic [`BYTE_W-1:0] result_high_byte_reg;
  logic [`BYTE_W-1:0] result_low_byte_reg;
  logic [`TICK_W-1:0] tick_count_reg;
  logic [`TICK_W-1:0] tick_count_next;
  logic [`IRQ_W-1:0] irq_status_reg;
  logic [`IRQ_W-1:0] irq_enable_reg;
  logic enable_reg;
  logic rc_sync1_reg;
  logic rc_sync2_reg;
  logic rc_prev_reg;
  logic [31:0] read_mux;
  logic [`BYTE_W-1:0] fmt_high;
  logic [`BYTE_W-1:0] fmt_low;
  wire conv_tick;
  wire rc_pulse;
  wire bus_req;
  wire bus_take;
  wire wr_take;
  wire lane0;
  wire sel_ctrl2;
  wire sel_high;
  wire sel_low;
  wire sel_conv;
  wire sel_clear;
  wire sel_enable;
  wire wr_ctrl2;
  wire wr_high;
  wire wr_low;
  wire wr_conv;
  wire wr_clear;
  wire wr_enable;
  wire go_written;
  wire en_written;
  wire start_req;
  wire abort_req;
  wire busy;
  wire finishing;
  wire last_tick;
  wire [`IRQ_W-1:0] irq_set;
  wire [`IRQ_W-1:0] irq_clr;
  wire [`BYTE_W-1:0] conv_read;

  // bus decode
  assign bus_req = read || write;
  assign bus_take = bus_req && !waitrequest;
  assign wr_take = write && !waitrequest;
  assign lane0 = byteenable[0];
  assign sel_ctrl2 = (address == `OFF_CONTROL_TWO);
  assign sel_high = (address == `OFF_RESULT_HIGH);
  assign sel_low = (address == `OFF_RESULT_LOW);
  assign sel_conv = (address == `OFF_CONV_CONTROL);
  assign sel_clear = (address == `OFF_IRQ_CLEAR);
  assign sel_enable = (address == `OFF_IRQ_ENABLE);
  assign wr_ctrl2 = wr_take && lane0 && sel_ctrl2;
  assign wr_high = wr_take && lane0 && sel_high;
  assign wr_low = wr_take && lane0 && sel_low;
  assign wr_conv = wr_take && lane0 && sel_conv;
  assign wr_clear = wr_take && lane0 && sel_clear;
  assign wr_enable = wr_take && lane0 && sel_enable;

  // conversion control decode
  assign go_written = writedata[`CONV_GO_BIT];
  assign en_written = writedata[`CONV_ENABLE_BIT];
  assign busy = (state_reg != adc_result_pkg::st_idle);
  assign start_req = wr_conv && go_written && en_written && !busy;
  // clearing go or powering down mid-conversion throws the result away
  assign abort_req = wr_conv && busy && (!go_written || !en_written);
  assign last_tick = conv_tick &&
                     (tick_count_reg == (`CONV_TICKS - `TICK_ONE));
  assign finishing = (state_reg == adc_result_pkg::st_finish);
  assign conv_read = {6'h00, busy, enable_reg};

  // interrupt set and clear; set wins when both land together
  assign irq_set = {`IRQ_W{finishing}};
  assign irq_clr = wr_clear ? writedata[`IRQ_W-1:0] : `IRQ_RESET;

  // rc oscillator arrives from outside: two flops, then edge detect
  assign rc_pulse = rc_sync2_reg && !rc_prev_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rc_sync1_reg <= 1'b0;
      rc_sync2_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end else begin
      rc_sync1_reg <= rc_osc_pin;
      rc_sync2_reg <= rc_sync1_reg;
      rc_prev_reg <= rc_sync2_reg;
    end
  end

  conv_clock_divider u_divider (
    .clock(clock),
    .nrst(nrst),
    .clock_select(control_two_reg[`CLKSEL_MSB:`CLKSEL_LSB]),
    .rc_pulse(rc_pulse),
    .conv_tick(conv_tick)
  );

  result_formatter u_formatter (
    .conversion_result(conversion_sample),
    .result_justify_select(control_two_reg[`JUSTIFY_BIT]),
    .high_byte(fmt_high),
    .low_byte(fmt_low)
  );

  // sequencer
  always_comb begin
    state_next = state_reg;
    tick_count_next = tick_count_reg;
    unique case (state_reg)
      adc_result_pkg::st_idle: begin
        if (start_req) begin
          state_next = adc_result_pkg::st_convert;
          tick_count_next = `TICK_ZERO;
        end
      end
      adc_result_pkg::st_convert: begin
        if (abort_req) begin
          state_next = adc_result_pkg::st_idle;
        end else if (last_tick) begin
          state_next = adc_result_pkg::st_finish;
        end else if (conv_tick) begin
          tick_count_next = tick_count_reg + `TICK_ONE;
        end
      end
      adc_result_pkg::st_finish: begin
        state_next = adc_result_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= adc_result_pkg::st_idle;
      tick_count_reg <= `TICK_ZERO;
    end else begin
      state_reg <= state_next;
      tick_count_reg <= tick_count_next;
    end
  end

  // configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      control_two_reg <= `CTRL2_RESET;
      enable_reg <= 1'b0;
      irq_enable_reg <= `IRQ_RESET;
    end else begin
      if (wr_ctrl2) begin
        control_two_reg <= writedata[`BYTE_W-1:0] & `CTRL2_WMASK;
      end
      if (wr_conv) begin
        enable_reg <= en_written;
      end
      if (wr_enable) begin
        irq_enable_reg <= writedata[`IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_status_reg <= `IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
    end
  end

  // result bytes carry no reset: they survive every reset untouched
  always_ff @(posedge clock) begin
    if (finishing) begin
      result_high_byte_reg <= fmt_high;
      result_low_byte_reg <= fmt_low;
    end else begin
      if (wr_high) begin
        result_high_byte_reg <= writedata[`BYTE_W-1:0];
      end
      if (wr_low) begin
        result_low_byte_reg <= writedata[`BYTE_W-1:0];
      end
    end
  end

  // read selection; unmapped and write-only words read as zero
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (address)
      `OFF_CONTROL_TWO: read_mux[`BYTE_W-1:0] = control_two_reg;
      `OFF_RESULT_HIGH: read_mux[`BYTE_W-1:0] = result_high_byte_reg;
      `OFF_RESULT_LOW: read_mux[`BYTE_W-1:0] = result_low_byte_reg;
      `OFF_CONV_CONTROL: read_mux[`BYTE_W-1:0] = conv_read;
      `OFF_IRQ_STATUS: read_mux[`IRQ_W-1:0] = irq_status_reg;
      `OFF_IRQ_ENABLE: read_mux[`IRQ_W-1:0] = irq_enable_reg;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // one wait cycle per access: data is latched as waitrequest drops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= !(bus_req && waitrequest);
      if (read && waitrequest) begin
        readdata <= read_mux;
      end
    end
  end

  // outputs straight from flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
      positive_reference_select <= 2'h0;
      converter_enable <= 1'b0;
      conversion_active <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_enable_reg);
      positive_reference_select <=
        control_two_reg[`PREF_MSB:`PREF_LSB];
      converter_enable <= enable_reg;
      conversion_active <= (state_next != adc_result_pkg::st_idle);
    end
  end
endmodule // adc_result_format_config
`default_nettype wire

/* adc_result_format_config_props.sv */
// concurrent checks on the converter result and configuration ports
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_consts.svh"
module adc_result_format_config_props (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [`ADDR_W-1:0] address, // word address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [3:0] byteenable, // byte enables
  input wire logic [31:0] writedata, // write data
  input wire logic [31:0] readdata, // read data
  input wire logic waitrequest, // bus wait
  input wire logic [`RESULT_W-1:0] conversion_sample, // front-end value
  input wire logic rc_osc_pin, // rc oscillator
  input wire logic irq, // interrupt
  input wire logic [1:0] positive_reference_select, // reference
  input wire logic converter_enable, // converter on
  input wire logic conversion_active // busy
);
  logic jq, act_q, vld;
  wire wr_ok = write && !waitrequest && byteenable[0];
  wire rd_ok = read && !waitrequest && vld;
  wire rd_hi = rd_ok && address == `OFF_RESULT_HIGH;
  wire rd_lo = rd_ok && address == `OFF_RESULT_LOW;
  wire [`RESULT_W-1:0] s = conversion_sample;
  // software writes to layout or result bytes void the expectation
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      jq <= 1'b0;
      act_q <= 1'b0;
      vld <= 1'b0;
    end else begin
      act_q <= conversion_active;
      if (wr_ok && address == `OFF_CONTROL_TWO) jq <= writedata[7];
      if (conversion_active || (wr_ok && address < 3'h3)) vld <= 1'b0;
      else if (act_q) vld <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_bus_answer: assert property ((read || write) && waitrequest
    |=> !waitrequest ##1 waitrequest) else $error("answer not one cycle");
  a_bus_rest: assert property (!read && !write |=> waitrequest)
    else $error("waitrequest low without request");
  a_reset_clear: assert property ($rose(nrst) |->
    positive_reference_select == 2'h0 && !conversion_active)
    else $error("outputs not cleared by reset");
  a_start_active: assert property (wr_ok && address == 3'h3 &&
    writedata[1:0] == 2'h3 && !conversion_active |=> conversion_active)
    else $error("start did not raise active");
  a_left_high: assert property (rd_hi && !jq |->
    readdata[7:0] == s[9:2]) else $error("left high byte wrong");
  a_left_low: assert property (rd_lo && !jq |->
    readdata[7:0] == {s[1:0], 6'h00}) else $error("left low byte wrong");
  a_right_high: assert property (rd_hi && jq |->
    readdata[7:0] == {6'h00, s[9:8]}) else $error("right high byte wrong");
  a_right_low: assert property (rd_lo && jq |->
    readdata[7:0] == s[7:0]) else $error("right low byte wrong");
endmodule // adc_result_format_config_props
bind adc_result_format_config adc_result_format_config_props chk (
  .clock(clock), .nrst(nrst), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
  .conversion_sample(conversion_sample), .rc_osc_pin(rc_osc_pin),
  .positive_reference_select(positive_reference_select),
  .converter_enable(converter_enable),
  .conversion_active(conversion_active));
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the converter result and configuration block
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_consts.svh"
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic rc_osc_pin = 1'b0;
  logic [`ADDR_W-1:0] address = 3'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [`RESULT_W-1:0] conversion_sample = 10'h000;
  logic [31:0] readdata;
  logic waitrequest, irq, converter_enable, conversion_active;
  logic [1:0] positive_reference_select;
  logic [9:0] smp [3] = '{10'h2b5, 10'h3ff, 10'h001};
  int mismatches = 0;
  int checks = 0;
  adc_result_format_config dut (.clock(clock), .nrst(nrst),
    .address(address), .read(read), .write(write), .irq(irq),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .conversion_sample(conversion_sample),
    .rc_osc_pin(rc_osc_pin), .converter_enable(converter_enable),
    .positive_reference_select(positive_reference_select),
    .conversion_active(conversion_active));
  initial begin
    forever #10 clock = ~clock;
  end
  // rc oscillator runs free, ten system clocks a period
  initial begin
    forever begin
      repeat (5) @(posedge clock);
      rc_osc_pin <= ~rc_osc_pin;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    end_sim;
  end
  task check8(input string name, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task bus(input logic wr, input logic [2:0] a, input logic [7:0] d,
           output logic [7:0] q);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) mismatches++;
  endtask
  // start a conversion and count cycles until it is no longer active
  task run(output int n);
    logic [7:0] q;
    bus(1'b1, 3'h3, 8'h03, q);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (conversion_active === 1'b1 && n < 3000);
    if (n >= 3000) mismatches++;
  endtask
  task t_reset;
    logic [7:0] q;
    bus(1'b0, 3'h0, 8'h00, q);
    check8("control_two", 8'h00, q);
    check8("reference", 8'h00, {6'h00, positive_reference_select});
    bus(1'b0, 3'h7, 8'h00, q);
    check8("unmapped", 8'h00, q);
  endtask
  task t_format;
    logic [7:0] q;
    logic [9:0] s;
    int n;
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 3; k++) begin
        s = smp[k];
        conversion_sample <= s;
        bus(1'b1, 3'h0, {j[0], 7'h00}, q);
        run(n);
        bus(1'b0, 3'h1, 8'h00, q);
        check8("result_high", j ? {6'h00, s[9:8]} : s[9:2], q);
        bus(1'b0, 3'h2, 8'h00, q);
        check8("result_low", j ? s[7:0] : {s[1:0], 6'h00}, q);
        bus(1'b0, 3'h3, 8'h00, q);
        check8("busy", 8'h01, q);
        check8("converter_enable", 8'h01, {7'h0, converter_enable});
      end
    end
  endtask
  task t_clksel;
    logic [7:0] q;
    int n, r;
    bus(1'b1, 3'h0, 8'hff, q);
    bus(1'b0, 3'h0, 8'h00, q);
    check8("control_two", 8'hf3, q);
    check8("reference", 8'h03, {6'h00, positive_reference_select});
    for (int c = 0; c < 8; c++) begin
      r = (c == 3 || c == 7) ? 10 : (c > 3 ? 4 : 2) << (2 * (c % 4));
      bus(1'b1, 3'h0, {1'b0, c[2:0], 4'h0}, q);
      run(n);
      check8("conv_len", 8'h01, {7'h0, n >= 10 * r && n <= 11 * r + 6});
    end
  endtask
  task t_irq;
    logic [7:0] q;
    int n;
    bus(1'b1, 3'h6, 8'h01, q);
    bus(1'b1, 3'h5, 8'h01, q);
    run(n);
    repeat (2) @(posedge clock);
    #1;
    check8("irq", 8'h01, {7'h0, irq});
    bus(1'b1, 3'h5, 8'h01, q);
    repeat (2) @(posedge clock);
    #1;
    check8("irq", 8'h00, {7'h0, irq});
    bus(1'b1, 3'h6, 8'h00, q);
    run(n);
    bus(1'b0, 3'h4, 8'h00, q);
    check8("status", 8'h01, q);
    check8("irq", 8'h00, {7'h0, irq});
  endtask
  // results survive a reset that clears the layout register
  task t_keep;
    logic [7:0] q;
    int n;
    conversion_sample <= 10'h155;
    bus(1'b1, 3'h0, 8'h80, q);
    run(n);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    bus(1'b0, 3'h0, 8'h00, q);
    check8("control_two", 8'h00, q);
    bus(1'b0, 3'h2, 8'h00, q);
    check8("result_low", 8'h55, q);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    t_format;
    t_clksel;
    t_irq;
    t_keep;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
